// [ppra_addr_map.sv]
`timescale 1ns/1ns
`default_nettype none
module ppra_addr_map (
	// Register contents and mode.
	input wire logic [23:0] raw_in,
	input wire logic [1:0] chip_select_function_in,
	input wire logic extended_address_enable_in,
	input wire logic dual_buffer_enable_in,
	// Decoded address and chip selects.
	output logic [23:0] read_target_address_out,
	output logic chip_sel_two_alt_flag_out,
	output logic chip_sel_one_alt_flag_out,
	output logic read_chip_sel_two_out,
	output logic read_chip_sel_one_out
);
	import ppra_pkg::*;

	wire ext_ok = extended_address_enable_in & dual_buffer_enable_in;
	wire csf_addr = (chip_select_function_in == PPRA_CSF_ADDR);
	wire csf_one = (chip_select_function_in == PPRA_CSF_ONE);
	wire csf_both = (chip_select_function_in == PPRA_CSF_BOTH);
	wire csf_any = csf_one | csf_both;

	assign chip_sel_two_alt_flag_out = csf_any & raw_in[23];
	assign read_target_address_out[23] = csf_addr & ext_ok & raw_in[23];
	assign chip_sel_one_alt_flag_out = csf_both & raw_in[22];
	assign read_target_address_out[22] = csf_addr & ext_ok & raw_in[22];
	assign read_target_address_out[21:16] = ext_ok ? raw_in[21:16] : 6'h00;
	assign read_chip_sel_two_out = csf_any & raw_in[15];
	assign read_target_address_out[15] = csf_addr & raw_in[15];
	assign read_chip_sel_one_out = csf_both & raw_in[14];
	assign read_target_address_out[14] = (csf_addr | csf_one) & raw_in[14];
	assign read_target_address_out[13:0] = raw_in[13:0];

endmodule : ppra_addr_map
`default_nettype wire

// [ppra_pkg.sv]
package ppra_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [7:0] PPRA_OFS_READ_ADDR = 8'h00;
	localparam logic [7:0] PPRA_OFS_CTRL = 8'h04;
	localparam logic [7:0] PPRA_OFS_CMD = 8'h08;
	localparam logic [7:0] PPRA_OFS_STAT = 8'h0C;
	localparam logic [7:0] PPRA_OFS_BASE = 8'h10;
	localparam logic [7:0] PPRA_OFS_DATA = 8'h14;

	// Field positions.
	localparam int PPRA_ADDR_IMPL_MSB = 23;
	localparam int PPRA_CTRL_CSF_LSB = 6;
	localparam int PPRA_CTRL_EXT_BIT = 8;
	localparam int PPRA_CTRL_DUAL_BIT = 17;
	localparam int PPRA_CMD_START_BIT = 0;
	localparam int PPRA_STAT_BUSY_BIT = 0;
	localparam int PPRA_STAT_DONE_BIT = 1;

	// Writable bits of each register.
	localparam logic [31:0] PPRA_ADDR_WMASK = 32'h00FF_FFFF;
	localparam logic [31:0] PPRA_CTRL_WMASK = 32'h0002_01C0;
	localparam logic [31:0] PPRA_BASE_WMASK = 32'h0000_FFFF;

	// Reset values.
	localparam logic [31:0] PPRA_ADDR_RESET = 32'h0000_0000;
	localparam logic [31:0] PPRA_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] PPRA_BASE_RESET = 32'h0000_0000;
	localparam logic [7:0] PPRA_DATA_RESET = 8'h00;

	// Chip-select function encodings.
	localparam logic [1:0] PPRA_CSF_ADDR = 2'b00;
	localparam logic [1:0] PPRA_CSF_ONE = 2'b01;
	localparam logic [1:0] PPRA_CSF_BOTH = 2'b10;

	// Read cycle phase times and derived cycle counts at 125 MHz.
	localparam int PPRA_CLK_PERIOD_PS = 8000;
	localparam int PPRA_SETUP_NS = 16;
	localparam int PPRA_STROBE_NS = 40;
	localparam int PPRA_HOLD_NS = 16;
	localparam int PPRA_SETUP_CYC = (PPRA_SETUP_NS * 1000 + PPRA_CLK_PERIOD_PS - 1)
		/ PPRA_CLK_PERIOD_PS;
	localparam int PPRA_STROBE_CYC = (PPRA_STROBE_NS * 1000 + PPRA_CLK_PERIOD_PS - 1)
		/ PPRA_CLK_PERIOD_PS;
	localparam int PPRA_HOLD_CYC = (PPRA_HOLD_NS * 1000 + PPRA_CLK_PERIOD_PS - 1)
		/ PPRA_CLK_PERIOD_PS;

	typedef enum logic [3:0] {
		PPRA_ST_IDLE = 4'b0001,
		PPRA_ST_SETUP = 4'b0010,
		PPRA_ST_STROBE = 4'b0100,
		PPRA_ST_HOLD = 4'b1000
	} ppra_state_e;

endpackage : ppra_pkg

// [ppra_pmp_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ppra_pmp_model (
	// Clock and port pins.
	input wire logic core_clk_in,
	input wire logic [23:0] pmp_addr_in,
	input wire logic pmp_rd_strobe_in,
	input wire logic slow_in,
	output logic [7:0] pmp_data_out
);
	logic seen_r;
	initial seen_r = 1'b0;
	initial pmp_data_out = 8'h3C;
	// Outside the strobe the lines toggle, so a stale byte can never pass for a capture.
	always @(posedge core_clk_in) begin
		seen_r <= pmp_rd_strobe_in;
		if (pmp_rd_strobe_in && (!slow_in || seen_r)) begin
			pmp_data_out <= pmp_addr_in[7:0] ^ 8'hA5;
		end else begin
			pmp_data_out <= ~pmp_data_out;
		end
	end
endmodule : ppra_pmp_model
`default_nettype wire

// [ppra_read_port.sv]
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ppra_read_port #(
	parameter int SETUP_CYC = ppra_pkg::PPRA_SETUP_CYC,
	parameter int STROBE_CYC = ppra_pkg::PPRA_STROBE_CYC,
	parameter int HOLD_CYC = ppra_pkg::PPRA_HOLD_CYC,
	parameter int DATA_W = 8
) (
	// Clock, reset and clock enable.
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic core_ce_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Parallel port pins.
	input wire logic [DATA_W-1:0] pmp_data_in,
	output logic [23:0] pmp_addr_out,
	output logic pmp_chip_sel_two_alt_flag_out,
	output logic pmp_chip_sel_one_alt_flag_out,
	output logic pmp_cs2_out,
	output logic pmp_cs1_out,
	output logic pmp_rd_strobe_out,
	output logic pmp_busy_out
);
	import ppra_pkg::*;

	localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
	localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
	localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYC - 1);

	// Registers.
	logic [31:0] read_cycle_address_r;
	logic [31:0] read_cycle_address_nxt;
	logic [31:0] port_control_register_r;
	logic [31:0] port_control_register_nxt;
	logic [31:0] base_addr_r;
	logic [31:0] base_addr_nxt;
	logic [DATA_W-1:0] read_data_r;
	logic done_r;
	logic done_nxt;

	// APB response.
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;

	// Pin synchroniser.
	logic [DATA_W-1:0] data_meta_r;
	logic [DATA_W-1:0] data_sync_r;

	// Read cycle engine.
	ppra_state_e state_r;
	ppra_state_e state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [23:0] addr_r;
	logic chip_sel_two_alt_flag_r;
	logic chip_sel_one_alt_flag_r;
	logic cs2_r;
	logic cs1_r;
	logic strobe_r;
	logic busy_r;

	// Bus decode.
	wire apb_access = psel_in & penable_in & ~pready_r;
	wire apb_fire = psel_in & penable_in & pready_r;
	wire wr_fire = apb_fire & pwrite_in;
	wire hit_addr = (paddr_in == PPRA_OFS_READ_ADDR);
	wire hit_ctrl = (paddr_in == PPRA_OFS_CTRL);
	wire hit_cmd = (paddr_in == PPRA_OFS_CMD);
	wire hit_stat = (paddr_in == PPRA_OFS_STAT);
	wire hit_base = (paddr_in == PPRA_OFS_BASE);
	wire hit_data = (paddr_in == PPRA_OFS_DATA);
	wire hit_any = hit_addr | hit_ctrl | hit_cmd | hit_stat | hit_base | hit_data;
	wire [31:0] byte_mask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}},
		{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

	// Write merges, each limited to the implemented bits.
	wire [31:0] addr_wmask = byte_mask & PPRA_ADDR_WMASK;
	wire [31:0] ctrl_wmask = byte_mask & PPRA_CTRL_WMASK;
	wire [31:0] base_wmask = byte_mask & PPRA_BASE_WMASK;
	assign read_cycle_address_nxt = (wr_fire & hit_addr)
		? ((read_cycle_address_r & ~addr_wmask) | (pwdata_in & addr_wmask))
		: read_cycle_address_r;
	assign port_control_register_nxt = (wr_fire & hit_ctrl)
		? ((port_control_register_r & ~ctrl_wmask) | (pwdata_in & ctrl_wmask))
		: port_control_register_r;
	assign base_addr_nxt = (wr_fire & hit_base)
		? ((base_addr_r & ~base_wmask) | (pwdata_in & base_wmask))
		: base_addr_r;

	// Mode fields.
	wire [1:0] chip_select_function = port_control_register_r[PPRA_CTRL_CSF_LSB+1:PPRA_CTRL_CSF_LSB];
	wire ext_en = port_control_register_r[PPRA_CTRL_EXT_BIT];
	wire dual_en = port_control_register_r[PPRA_CTRL_DUAL_BIT];

	// Start command, taken only while the engine is idle.
	wire start_req = wr_fire & hit_cmd & pstrb_in[0] & pwdata_in[PPRA_CMD_START_BIT];
	wire idle = (state_r == PPRA_ST_IDLE);
	wire start_go = start_req & idle;
	wire cycle_end = (state_r == PPRA_ST_HOLD) & (cnt_r == 4'h0);

	// Done flag: a cycle ending in the same write that clears it keeps it set.
	wire done_clr = wr_fire & hit_stat & pstrb_in[0] & pwdata_in[PPRA_STAT_DONE_BIT];
	assign done_nxt = cycle_end ? 1'b1 : (done_clr ? 1'b0 : done_r);

	// Decoded view of the read-address register.
	wire [23:0] map_addr;
	wire map_chip_sel_two_alt_flag;
	wire map_chip_sel_one_alt_flag;
	wire map_cs2;
	wire map_cs1;

	ppra_addr_map u_addr_map (
		.raw_in(read_cycle_address_r[PPRA_ADDR_IMPL_MSB:0]),
		.chip_select_function_in(chip_select_function),
		.extended_address_enable_in(ext_en),
		.dual_buffer_enable_in(dual_en),
		.read_target_address_out(map_addr),
		.chip_sel_two_alt_flag_out(map_chip_sel_two_alt_flag),
		.chip_sel_one_alt_flag_out(map_chip_sel_one_alt_flag),
		.read_chip_sel_two_out(map_cs2),
		.read_chip_sel_one_out(map_cs1)
	);

	// Without dual buffering the read cycle takes the shared base address.
	wire [23:0] cyc_addr = dual_en ? map_addr : {8'h00, base_addr_r[15:0]};
	wire cyc_chip_sel_two_alt_flag = dual_en & map_chip_sel_two_alt_flag;
	wire cyc_chip_sel_one_alt_flag = dual_en & map_chip_sel_one_alt_flag;
	wire cyc_cs2 = dual_en & map_cs2;
	wire cyc_cs1 = dual_en & map_cs1;

	// Read-back multiplexer.
	wire [31:0] stat_word = {30'h0, done_r, ~idle};
	wire [31:0] data_word = {{(32-DATA_W){1'b0}}, read_data_r};
	wire [31:0] rd_word =
		hit_addr ? {8'h00, read_cycle_address_r[PPRA_ADDR_IMPL_MSB:0]} :
		hit_ctrl ? port_control_register_r :
		hit_stat ? stat_word :
		hit_base ? base_addr_r :
		hit_data ? data_word :
		32'h0000_0000;

	// Phase sequencing.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			PPRA_ST_IDLE: begin
				if (start_go) begin
					state_nxt = PPRA_ST_SETUP;
					cnt_nxt = SETUP_LAST;
				end
			end
			PPRA_ST_SETUP: begin
				if (cnt_r == 4'h0) begin
					state_nxt = PPRA_ST_STROBE;
					cnt_nxt = STROBE_LAST;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			PPRA_ST_STROBE: begin
				if (cnt_r == 4'h0) begin
					state_nxt = PPRA_ST_HOLD;
					cnt_nxt = HOLD_LAST;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			PPRA_ST_HOLD: begin
				if (cnt_r == 4'h0) begin
					state_nxt = PPRA_ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			default: begin
				state_nxt = PPRA_ST_IDLE;
				cnt_nxt = 4'h0;
			end
		endcase
	end

	wire strobe_nxt = (state_nxt == PPRA_ST_STROBE);
	// Busy follows the next state so the pin leaves a flip-flop in step with the state.
	wire busy_nxt = (state_nxt != PPRA_ST_IDLE);
	wire capture = (state_r == PPRA_ST_STROBE) & (cnt_r == 4'h0);

	// Read-address register.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			read_cycle_address_r <= PPRA_ADDR_RESET;
		end else if (core_ce_in) begin
			read_cycle_address_r <= read_cycle_address_nxt;
		end
	end

	// Control and base address registers.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			port_control_register_r <= PPRA_CTRL_RESET;
			base_addr_r <= PPRA_BASE_RESET;
		end else if (core_ce_in) begin
			port_control_register_r <= port_control_register_nxt;
			base_addr_r <= base_addr_nxt;
		end
	end

	// Sticky done flag.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			done_r <= 1'b0;
		end else if (core_ce_in) begin
			done_r <= done_nxt;
		end
	end

	// APB answer one cycle into the access phase.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (core_ce_in) begin
			pready_r <= apb_access;
			pslverr_r <= apb_access & ~hit_any;
		end
	end

	// Read data is latched with the answer; writes return zero.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			prdata_r <= 32'h0000_0000;
		end else if (core_ce_in && apb_access) begin
			prdata_r <= pwrite_in ? 32'h0000_0000 : rd_word;
		end
	end

	// Two-stage synchroniser on the data pins.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			data_meta_r <= '0;
			data_sync_r <= '0;
		end else if (core_ce_in) begin
			data_meta_r <= pmp_data_in;
			data_sync_r <= data_meta_r;
		end
	end

	// Captured read data.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			read_data_r <= PPRA_DATA_RESET[DATA_W-1:0];
		end else if (core_ce_in && capture) begin
			read_data_r <= data_sync_r;
		end
	end

	// Engine state.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			state_r <= PPRA_ST_IDLE;
			cnt_r <= 4'h0;
		end else if (core_ce_in) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Strobe and busy pins.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			strobe_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (core_ce_in) begin
			strobe_r <= strobe_nxt;
			busy_r <= busy_nxt;
		end
	end

	// The address is latched at the start and kept after the cycle.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			addr_r <= 24'h00_0000;
		end else if (core_ce_in && start_go) begin
			addr_r <= cyc_addr;
		end
	end

	// Chip selects are latched at the start and dropped at the end of the hold phase.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			chip_sel_two_alt_flag_r <= 1'b0;
			chip_sel_one_alt_flag_r <= 1'b0;
			cs2_r <= 1'b0;
			cs1_r <= 1'b0;
		end else if (core_ce_in) begin
			if (start_go) begin
				chip_sel_two_alt_flag_r <= cyc_chip_sel_two_alt_flag;
				chip_sel_one_alt_flag_r <= cyc_chip_sel_one_alt_flag;
				cs2_r <= cyc_cs2;
				cs1_r <= cyc_cs1;
			end else if (cycle_end) begin
				chip_sel_two_alt_flag_r <= 1'b0;
				chip_sel_one_alt_flag_r <= 1'b0;
				cs2_r <= 1'b0;
				cs1_r <= 1'b0;
			end
		end
	end

	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	assign pmp_addr_out = addr_r;
	assign pmp_chip_sel_two_alt_flag_out = chip_sel_two_alt_flag_r;
	assign pmp_chip_sel_one_alt_flag_out = chip_sel_one_alt_flag_r;
	assign pmp_cs2_out = cs2_r;
	assign pmp_cs1_out = cs1_r;
	assign pmp_rd_strobe_out = strobe_r;
	assign pmp_busy_out = busy_r;

endmodule : ppra_read_port
`default_nettype wire

// [ppra_read_port_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module ppra_read_port_checker #(
	parameter int STROBE_CYC = ppra_pkg::PPRA_STROBE_CYC
) (
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Register bus.
	input wire logic core_ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	// Port pins.
	input wire logic [23:0] pmp_addr_out,
	input wire logic pmp_chip_sel_two_alt_flag_out,
	input wire logic pmp_chip_sel_one_alt_flag_out,
	input wire logic pmp_cs2_out,
	input wire logic pmp_cs1_out,
	input wire logic pmp_rd_strobe_out,
	input wire logic pmp_busy_out
);
	import ppra_pkg::*;
	int strb_cnt_r;
	wire logic any_cs = pmp_chip_sel_two_alt_flag_out | pmp_chip_sel_one_alt_flag_out | pmp_cs2_out | pmp_cs1_out;
	wire logic [27:0] pins = {pmp_chip_sel_two_alt_flag_out, pmp_chip_sel_one_alt_flag_out, pmp_cs2_out, pmp_cs1_out, pmp_addr_out};
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// Counts strobe cycles so the strobe width can be compared on its falling edge.
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in || !pmp_rd_strobe_out) begin
			strb_cnt_r <= 0;
		end else begin
			strb_cnt_r <= strb_cnt_r + 1;
		end
	end
	property p_rdy_pulse; pready_out |=> !pready_out; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
	property p_rdy_wait; psel_in && penable_in && !pready_out && core_ce_in |=> pready_out; endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
	property p_top; pready_out && !pwrite_in && paddr_in == PPRA_OFS_READ_ADDR
		|-> prdata_out[31:24] == 8'h00; endproperty
	a_top: assert property (p_top) else $error("upper read bits not zero");
	property p_cs_one; pmp_cs1_out || pmp_chip_sel_one_alt_flag_out
		|-> pmp_addr_out[23:22] == 2'b00 && pmp_addr_out[15:14] == 2'b00; endproperty
	a_cs_one: assert property (p_cs_one) else $error("address bit under select");
	property p_cs_two; pmp_cs2_out || pmp_chip_sel_two_alt_flag_out |-> !pmp_addr_out[23] && !pmp_addr_out[15];
	endproperty
	a_cs_two: assert property (p_cs_two) else $error("address bit under select");
	property p_strb_len; $fell(pmp_rd_strobe_out) |-> strb_cnt_r == STROBE_CYC; endproperty
	a_strb_len: assert property (p_strb_len) else $error("strobe width wrong");
	property p_setup; $rose(pmp_busy_out) |-> !pmp_rd_strobe_out [*2] ##1 pmp_rd_strobe_out;
	endproperty
	a_setup: assert property (p_setup) else $error("setup phase length wrong");
	property p_hold; pmp_busy_out && $past(pmp_busy_out) |-> $stable(pins); endproperty
	a_hold: assert property (p_hold) else $error("pins moved during cycle");
	property p_idle; !pmp_busy_out |-> !any_cs; endproperty
	a_idle: assert property (p_idle) else $error("select active while idle");
endmodule : ppra_read_port_checker
bind ppra_read_port ppra_read_port_checker #(.STROBE_CYC(STROBE_CYC)) i_chk (.core_clk_in,
	.resetn_in, .core_ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
	.pready_out, .pmp_addr_out, .pmp_chip_sel_two_alt_flag_out, .pmp_chip_sel_one_alt_flag_out, .pmp_cs2_out, .pmp_cs1_out,
	.pmp_rd_strobe_out, .pmp_busy_out);
`default_nettype wire

// [ppra_read_port_test.sv]
`timescale 1ns/1ns
`default_nettype none
module ppra_read_port_test;
	import ppra_pkg::*;
	localparam logic [15:0] BASE_V = 16'hB7E9;
	logic core_clk_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic pmp_chip_sel_two_alt_flag_out, pmp_chip_sel_one_alt_flag_out, pmp_cs2_out, pmp_cs1_out, pmp_rd_strobe_out;
	logic pmp_busy_out, slow_in, err;
	logic [7:0] paddr_in, pmp_data_in;
	logic [3:0] pstrb_in;
	logic [31:0] pwdata_in, prdata_out, rdata, cv;
	logic [23:0] pmp_addr_out, raw;
	int fails = 0, check_count = 0, cyc_cnt = 0;
	ppra_read_port i_dut (.core_clk_in, .resetn_in, .core_ce_in(1'b1), .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
		.pmp_data_in, .pmp_addr_out, .pmp_chip_sel_two_alt_flag_out, .pmp_chip_sel_one_alt_flag_out, .pmp_cs2_out, .pmp_cs1_out,
		.pmp_rd_strobe_out, .pmp_busy_out);
	ppra_pmp_model i_mem (.core_clk_in, .pmp_addr_in(pmp_addr_out),
		.pmp_rd_strobe_in(pmp_rd_strobe_out), .slow_in, .pmp_data_out(pmp_data_in));
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	always @(posedge core_clk_in) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			fails++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		pstrb_in <= s;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		do @(posedge core_clk_in); while (pready_out !== 1'b1);
		rdata = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0, 4'hF);
		chk(what, exp, rdata);
	endtask : rchk
	function automatic logic [27:0] emap(input logic [23:0] r, input logic [1:0] f,
		input logic x, input logic d);
		logic [27:0] e;
		logic ea;
		logic cs2;
		ea = f == PPRA_CSF_ADDR && x;
		cs2 = f == PPRA_CSF_ONE || f == PPRA_CSF_BOTH;
		e = {14'h0, r[13:0]};
		if (!d) return {12'h0, BASE_V};
		if (x) e[21:16] = r[21:16];
		e[23] = ea & r[23];
		e[22] = ea & r[22];
		e[15] = f == PPRA_CSF_ADDR & r[15];
		e[14] = (f == PPRA_CSF_ADDR || f == PPRA_CSF_ONE) & r[14];
		e[27] = cs2 & r[23];
		e[26] = f == PPRA_CSF_BOTH & r[22];
		e[25] = cs2 & r[15];
		e[24] = f == PPRA_CSF_BOTH & r[14];
		return e;
	endfunction : emap
	task automatic fire(input logic [27:0] ex, input logic twice);
		apb(1'b1, PPRA_OFS_CMD, 32'h1, 4'h1);
		if (twice) apb(1'b1, PPRA_OFS_CMD, 32'h1, 4'h1);
		while (pmp_rd_strobe_out !== 1'b1) @(posedge core_clk_in);
		chk("pins", {4'h0, ex}, {4'h0, pmp_chip_sel_two_alt_flag_out, pmp_chip_sel_one_alt_flag_out, pmp_cs2_out, pmp_cs1_out,
			pmp_addr_out});
		while (pmp_busy_out !== 1'b0) @(posedge core_clk_in);
		repeat (3) @(posedge core_clk_in);
		chk("pins after", {8'h0, ex[23:0]}, {3'h0, pmp_busy_out, pmp_chip_sel_two_alt_flag_out, pmp_chip_sel_one_alt_flag_out,
			pmp_cs2_out, pmp_cs1_out, pmp_addr_out});
		rchk(PPRA_OFS_STAT, 32'h2, "status");
		apb(1'b1, PPRA_OFS_STAT, 32'h2, 4'h1);
		rchk(PPRA_OFS_STAT, 32'h0, "status clear");
		rchk(PPRA_OFS_DATA, {24'h0, ex[7:0] ^ 8'hA5}, "byte");
	endtask : fire
	initial begin
		resetn_in = 1'b0;
		{psel_in, penable_in, pwrite_in, slow_in} = 4'h0;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		pstrb_in = 4'h0;
		repeat (4) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		rchk(PPRA_OFS_READ_ADDR, 32'h0, "address reset");
		rchk(PPRA_OFS_CTRL, 32'h0, "control reset");
		chk("pins reset", 32'h0, {2'h0, pmp_busy_out, pmp_rd_strobe_out, pmp_chip_sel_two_alt_flag_out,
			pmp_chip_sel_one_alt_flag_out, pmp_cs2_out, pmp_cs1_out, pmp_addr_out});
		$display("test reset done");
		apb(1'b1, PPRA_OFS_READ_ADDR, 32'hFFFF_FFFF, 4'hF);
		apb(1'b1, PPRA_OFS_READ_ADDR, 32'h1234_AA56, 4'h2);
		rchk(PPRA_OFS_READ_ADDR, 32'h00FF_AAFF, "address bytes");
		apb(1'b0, 8'h20, 32'h0, 4'hF);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rdata);
		apb(1'b1, PPRA_OFS_BASE, {16'h0, BASE_V}, 4'hF);
		$display("test register access done");
		for (int i = 0; i < 32; i++) begin
			raw = i[4] ? 24'hFF_FFFF : 24'h6A_8123;
			cv = {14'h0, i[0], 8'h0, i[1], i[3:2], 6'h0};
			slow_in <= i[1] ^ i[4];
			apb(1'b1, PPRA_OFS_READ_ADDR, {8'hFF, raw}, 4'hF);
			apb(1'b1, PPRA_OFS_CTRL, cv, 4'hF);
			rchk(PPRA_OFS_CTRL, cv, "control");
			fire(emap(raw, i[3:2], i[1], i[0]), i == 31);
		end
		$display("test mode sweep done");
		end_sim();
	end
endmodule : ppra_read_port_test
`default_nettype wire
